/* File: logic/pst_regs.vh */
// Constants for strap capture and fast nibble line coding.
`ifndef PST_REGS_VH
`define PST_REGS_VH

`define PST_CORE_MHZ 50
`define PST_LINK_NS 160
`define PST_NIB_CYC ((`PST_LINK_NS * `PST_CORE_MHZ) / 1000)
`define PST_BIT_CYC (`PST_NIB_CYC / 4)
`define PST_STRAP_WAIT 3'h3
`define PST_ADDR_RST 5'h01
`define PST_PU_RST 1'h1
`define PST_PD_RST 1'h0
`define PST_CTRL_SPEED 13
`define PST_CTRL_ANEG 12
`define PST_CTRL_DUPLEX 8
`define PST_ADV_100FD 8
`define PST_ADV_100HD 7
`define PST_ADV_10FD 6
`define PST_ADV_10HD 5
`define PST_ADV_SEL 0
`define PST_ACT_BITS 5'h10
`define PST_TX_SAMPLE 3'h2
// Idle pin levels: the pulled-up straps and the power pin read high.
`define PST_PIN_IDLE 21'h010e80

`endif

/* File: logic/pst_tx_enc.v */
// Transmit serializer with NRZI and three-level line encoder.
`timescale 1ns/1ns
`include "pst_regs.vh"

module pst_tx_enc (
  input wire clk, // Core clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire enable, // Low holds the line at zero level.
  input wire bit_en, // One-cycle pulse per line bit.
  input wire nib_load, // Loads the next nibble after the last bit.
  input wire [3:0] nibble, // Nibble to send, bit 0 first.
  output wire tx_pos, // Line at positive level.
  output wire tx_neg // Line at negative level.
);

  reg [3:0] shift_reg;
  reg nrzi_reg;
  reg [1:0] mlt_reg;
  wire nrzi_next;

  // NRZI toggles on every NRZ one.
  assign nrzi_next = nrzi_reg ^ shift_reg[0];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= 4'h0;
      nrzi_reg <= 1'b0;
      mlt_reg <= 2'h0;
    end else if (!enable) begin
      shift_reg <= 4'h0;
      nrzi_reg <= 1'b0;
      mlt_reg <= 2'h0;
    end else if (bit_en) begin
      if (nib_load) begin
        shift_reg <= nibble;
      end else begin
        shift_reg <= {1'b0, shift_reg[3:1]};
      end
      nrzi_reg <= nrzi_next;
      if (nrzi_next) begin
        mlt_reg <= mlt_reg + 2'h1;
      end
    end
  end

  // Sequence zero, positive, zero, negative.
  assign tx_pos = (mlt_reg == 2'h1);
  assign tx_neg = (mlt_reg == 2'h3);

endmodule

/* File: logic/pst_rx_dec.v */
// Receive level decoder, bit clock recovery and nibble builder.
`timescale 1ns/1ns
`include "pst_regs.vh"

module pst_rx_dec (
  input wire clk, // Core clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire enable, // Low forces the stored line levels to zero.
  input wire line_pos, // Line at positive level.
  input wire line_neg, // Line at negative level.
  output reg rxc, // Receive nibble clock.
  output reg [3:0] rxd, // Receive nibble.
  output wire active // Steps seen in recent bits.
);

  localparam [31:0] BIT_LAST_W = `PST_BIT_CYC - 1;
  localparam [2:0] BIT_LAST = BIT_LAST_W[2:0];

  reg [1:0] lvl_reg;
  reg [1:0] lvl_bit_reg;
  reg [2:0] phase_reg;
  reg nrzi_reg;
  reg [3:0] shift_reg;
  reg [1:0] bit_cnt_reg;
  reg [4:0] act_reg;
  wire [1:0] lvl;
  wire strobe;
  wire nrzi;
  wire nrz;

  assign lvl = {line_pos, line_neg};
  // Level change realigns the bit strobe; otherwise it free runs.
  assign strobe = (lvl != lvl_reg) || (phase_reg == BIT_LAST);
  assign nrzi = (lvl != lvl_bit_reg);
  assign nrz = nrzi ^ nrzi_reg;
  assign active = (act_reg != 5'h00);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_reg <= 2'h0;
      lvl_bit_reg <= 2'h0;
      phase_reg <= 3'h0;
      nrzi_reg <= 1'b0;
      shift_reg <= 4'h0;
      bit_cnt_reg <= 2'h0;
      act_reg <= 5'h00;
      rxc <= 1'b0;
      rxd <= 4'h0;
    end else begin
      lvl_reg <= enable ? lvl : 2'h0;
      if (!strobe) begin
        phase_reg <= phase_reg + 3'h1;
      end else begin
        phase_reg <= 3'h0;
        lvl_bit_reg <= enable ? lvl : 2'h0;
        nrzi_reg <= nrzi;
        shift_reg <= {nrz, shift_reg[3:1]};
        bit_cnt_reg <= bit_cnt_reg + 2'h1;
        rxc <= bit_cnt_reg[0] ^ bit_cnt_reg[1];
        if (nrzi) begin
          act_reg <= `PST_ACT_BITS;
        end else if (act_reg != 5'h00) begin
          act_reg <= act_reg - 5'h01;
        end
        if (bit_cnt_reg == 2'h3) begin
          rxd <= {nrz, shift_reg[3:1]};
        end
      end
    end
  end

endmodule

/* File: logic/pst_top.v */
// Strap capture and fast nibble datapath of the transceiver.
`timescale 1ns/1ns
`include "pst_regs.vh"

module pst_top (
  input wire CORE_CLK, // Core clock, 50 MHz.
  input wire RSTN, // Asynchronous reset, active low.
  input wire [3:0] RXD_I, // Address straps 4:1 during reset.
  output reg [3:0] RXD_O, // Receive nibble.
  output wire RXD_OE, // Receive nibble drive enable.
  input wire INT_N_I, // Address strap 0 during reset.
  output wire INT_N_O, // Interrupt, idle high.
  output wire INT_N_OE, // Interrupt drive enable.
  input wire RX_DV_I, // Loopback strap during reset.
  output reg RX_DV_O, // Receive data valid.
  output wire RX_DV_OE, // Data valid drive enable.
  input wire RX_ER_I, // Isolate strap during reset.
  output reg RX_ER_O, // Receive error.
  output wire RX_ER_OE, // Receive error drive enable.
  input wire COL_I, // Reduced interface strap during reset.
  output reg COL_O, // Collision.
  output wire COL_OE, // Collision drive enable.
  input wire CRS_I, // Back-to-back strap during reset.
  output reg CRS_O, // Carrier sense.
  output wire CRS_OE, // Carrier sense drive enable.
  input wire LED_SPEED_I, // Speed strap during reset.
  output reg LED_SPEED_O, // Speed indicator, low for fast.
  output wire LED_SPEED_OE, // Speed indicator drive enable.
  input wire LED_DUPLEX_I, // Duplex strap during reset.
  output reg LED_DUPLEX_O, // Duplex indicator, low for full.
  output wire LED_DUPLEX_OE, // Duplex indicator drive enable.
  input wire LED_ACT_I, // Negotiation strap during reset.
  output reg LED_ACT_O, // Activity indicator, low when active.
  output wire LED_ACT_OE, // Activity indicator drive enable.
  input wire FIBER_MODE_ENABLE_I, // Fiber mode strap.
  input wire POWER_DOWN_N, // Power down, active low.
  output reg TXC, // Transmit nibble clock.
  input wire [3:0] TXD, // Transmit nibble.
  input wire TX_EN, // Transmit enable.
  output wire RXC, // Receive nibble clock.
  output wire TX_POS, // Line driven to positive level.
  output wire TX_NEG, // Line driven to negative level.
  input wire RX_POS, // Line seen at positive level.
  input wire RX_NEG, // Line seen at negative level.
  output reg STRAP_DONE, // Straps have been captured.
  output reg [4:0] STRAP_MGMT_ADDRESS, // Captured management address.
  output reg CODING_LAYER_LOOPBACK, // Loopback mode.
  output reg ISOLATE_MODE, // Isolate mode.
  output reg RMII_MODE, // Reduced interface mode.
  output reg REDUCED_BACK_TO_BACK, // Back-to-back mode.
  output reg FIBER_MODE_ENABLE, // Fiber mode.
  output wire FAR_END_FAULT_DISABLE, // Far-end fault signalling off.
  output reg POWER_DOWN, // Power-down mode.
  output wire [15:0] CTRL_WORD, // Control word with strap bits.
  output wire [15:0] ADV_WORD // Advertisement word.
);

  localparam [31:0] NIB_LAST_W = `PST_NIB_CYC - 1;
  localparam [2:0] NIB_LAST = NIB_LAST_W[2:0];

  // Every asynchronous input passes two flip-flops.
  wire [20:0] pin_in;
  reg [20:0] sync1_reg;
  reg [20:0] sync2_reg;

  assign pin_in = {RXD_I, INT_N_I, RX_DV_I, RX_ER_I, COL_I, CRS_I,
                   LED_SPEED_I, LED_DUPLEX_I, LED_ACT_I,
                   FIBER_MODE_ENABLE_I, POWER_DOWN_N, TXD, TX_EN,
                   RX_POS, RX_NEG};

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      // Idle levels keep power-down from pulsing just after reset.
      sync1_reg <= `PST_PIN_IDLE;
      sync2_reg <= `PST_PIN_IDLE;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire [4:0] addr_s;
  wire lpbk_s;
  wire iso_s;
  wire rmii_s;
  wire btb_s;
  wire speed_select_strap;
  wire duplex_s;
  wire autoneg_enable_strap;
  wire fiber_s;
  wire power_down_n;
  wire [3:0] txd_s;
  wire tx_en_s;
  wire rx_pos_s;
  wire rx_neg_s;

  assign addr_s = sync2_reg[20:16];
  assign lpbk_s = sync2_reg[15];
  assign iso_s = sync2_reg[14];
  assign rmii_s = sync2_reg[13];
  assign btb_s = sync2_reg[12];
  assign speed_select_strap = sync2_reg[11];
  assign duplex_s = sync2_reg[10];
  assign autoneg_enable_strap = sync2_reg[9];
  assign fiber_s = sync2_reg[8];
  assign power_down_n = sync2_reg[7];
  assign txd_s = sync2_reg[6:3];
  assign tx_en_s = sync2_reg[2];
  assign rx_pos_s = sync2_reg[1];
  assign rx_neg_s = sync2_reg[0];

  // Straps are caught once the synchroniser holds post-release values.
  reg [2:0] strap_cnt_reg;
  wire strap_take;

  assign strap_take = !STRAP_DONE && (strap_cnt_reg == `PST_STRAP_WAIT);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_cnt_reg <= 3'h0;
      STRAP_DONE <= 1'b0;
    end else if (!STRAP_DONE) begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_take) begin
        STRAP_DONE <= 1'b1;
      end
    end
  end

  reg speed_reg;
  reg duplex_reg;
  reg aneg_reg;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      STRAP_MGMT_ADDRESS <= `PST_ADDR_RST;
      CODING_LAYER_LOOPBACK <= `PST_PD_RST;
      ISOLATE_MODE <= `PST_PD_RST;
      RMII_MODE <= `PST_PD_RST;
      REDUCED_BACK_TO_BACK <= `PST_PD_RST;
      FIBER_MODE_ENABLE <= `PST_PD_RST;
      speed_reg <= `PST_PU_RST;
      duplex_reg <= `PST_PU_RST;
      aneg_reg <= `PST_PU_RST;
    end else if (strap_take) begin
      // Later activity on the shared pins leaves these untouched.
      STRAP_MGMT_ADDRESS <= addr_s;
      CODING_LAYER_LOOPBACK <= lpbk_s;
      ISOLATE_MODE <= iso_s;
      RMII_MODE <= rmii_s;
      REDUCED_BACK_TO_BACK <= btb_s;
      FIBER_MODE_ENABLE <= fiber_s;
      speed_reg <= speed_select_strap;
      duplex_reg <= duplex_s;
      aneg_reg <= autoneg_enable_strap;
    end
  end

  // In fiber mode the speed strap means fault signalling, not speed.
  wire speed_100;

  assign speed_100 = FIBER_MODE_ENABLE | speed_reg;
  assign FAR_END_FAULT_DISABLE = FIBER_MODE_ENABLE & ~speed_reg;

  assign CTRL_WORD = {2'h0, speed_100, aneg_reg, 3'h0, duplex_reg,
                      8'h00};

  wire [15:0] adv;

  assign adv[15:`PST_ADV_100FD + 1] = 7'h00;
  // Advertised speed follows the strap itself, not the fiber override.
  assign adv[`PST_ADV_100FD] = speed_reg & duplex_reg;
  assign adv[`PST_ADV_100HD] = speed_reg;
  assign adv[`PST_ADV_10FD] = duplex_reg;
  assign adv[`PST_ADV_10HD] = 1'b1;
  assign adv[`PST_ADV_10HD - 1:`PST_ADV_SEL + 1] = 4'h0;
  assign adv[`PST_ADV_SEL] = 1'b1;
  assign ADV_WORD = adv;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      POWER_DOWN <= 1'b0;
    end else begin
      POWER_DOWN <= ~power_down_n;
    end
  end

  // Nibble timing from the reference; runs with or without line data.
  reg [2:0] nib_cnt_reg;
  reg [3:0] tx_hold_reg;
  reg tx_en_hold_reg;
  wire bit_en;
  wire nib_load;

  assign bit_en = nib_cnt_reg[0];
  assign nib_load = (nib_cnt_reg == NIB_LAST);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      nib_cnt_reg <= 3'h0;
      TXC <= 1'b0;
      tx_hold_reg <= 4'h0;
      tx_en_hold_reg <= 1'b0;
    end else begin
      nib_cnt_reg <= nib_cnt_reg + 3'h1;
      TXC <= ~nib_cnt_reg[2];
      // Value present at the rising TXC, seen through the synchroniser.
      if (nib_cnt_reg == `PST_TX_SAMPLE) begin
        tx_hold_reg <= tx_en_s ? txd_s : 4'h0;
        tx_en_hold_reg <= tx_en_s;
      end
    end
  end

  wire tx_pos_w;
  wire tx_neg_w;

  pst_tx_enc pst_tx_enc_i (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .enable(~POWER_DOWN),
    .bit_en(bit_en),
    .nib_load(nib_load),
    .nibble(tx_hold_reg),
    .tx_pos(tx_pos_w),
    .tx_neg(tx_neg_w)
  );

  // Loopback keeps the line quiet and feeds the receiver internally.
  assign TX_POS = tx_pos_w & ~CODING_LAYER_LOOPBACK;
  assign TX_NEG = tx_neg_w & ~CODING_LAYER_LOOPBACK;

  wire line_pos;
  wire line_neg;
  wire [3:0] rx_nib;
  wire rx_active;
  wire rxc_w;

  assign line_pos = CODING_LAYER_LOOPBACK ? tx_pos_w : rx_pos_s;
  assign line_neg = CODING_LAYER_LOOPBACK ? tx_neg_w : rx_neg_s;

  pst_rx_dec pst_rx_dec_i (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .enable(~POWER_DOWN),
    .line_pos(line_pos),
    .line_neg(line_neg),
    .rxc(rxc_w),
    .rxd(rx_nib),
    .active(rx_active)
  );

  assign RXC = rxc_w;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RXD_O <= 4'h0;
      RX_DV_O <= 1'b0;
      RX_ER_O <= 1'b0;
      CRS_O <= 1'b0;
      COL_O <= 1'b0;
      LED_SPEED_O <= 1'b1;
      LED_DUPLEX_O <= 1'b1;
      LED_ACT_O <= 1'b1;
    end else begin
      RXD_O <= rx_nib;
      RX_DV_O <= rx_active;
      RX_ER_O <= 1'b0;
      CRS_O <= rx_active | tx_en_hold_reg;
      COL_O <= rx_active & tx_en_hold_reg & ~duplex_reg;
      LED_SPEED_O <= ~speed_100;
      LED_DUPLEX_O <= ~duplex_reg;
      LED_ACT_O <= ~(rx_active | tx_en_hold_reg);
    end
  end

  // Shared pins stay inputs until straps are caught.
  wire mii_oe;

  assign mii_oe = STRAP_DONE & ~ISOLATE_MODE;
  assign RXD_OE = mii_oe;
  assign RX_DV_OE = mii_oe;
  assign RX_ER_OE = mii_oe;
  assign COL_OE = mii_oe;
  assign CRS_OE = mii_oe;
  assign INT_N_O = 1'b1;
  assign INT_N_OE = STRAP_DONE;
  assign LED_SPEED_OE = STRAP_DONE;
  assign LED_DUPLEX_OE = STRAP_DONE;
  assign LED_ACT_OE = STRAP_DONE;

endmodule

/* File: tb/pst_top_assertions.sv */
// Checker for the strap capture and nibble line coding ports.
`timescale 1ns/1ns
module pst_top_assertions (
  input wire CORE_CLK, // Clock.
  input wire RSTN, // Reset.
  input wire TXC, // Tx clock.
  input wire RXC, // Rx clock.
  input wire [3:0] RXD_O, // Rx nibble.
  input wire RXD_OE, // Rx drive.
  input wire TX_POS, // Line plus.
  input wire TX_NEG, // Line minus.
  input wire POWER_DOWN_N, // Power pin.
  input wire POWER_DOWN, // Power mode.
  input wire STRAP_DONE, // Captured.
  input wire ISOLATE_MODE, // Isolate.
  input wire [15:0] CTRL_WORD, // Control.
  input wire [15:0] ADV_WORD // Advert.
);
  reg [2:0] st_cnt_reg;
  reg [4:0] rxc_cnt_reg;
  reg rxc_reg;
  reg pos_reg;
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_cnt_reg <= 3'h0;
      rxc_cnt_reg <= 5'h00;
      rxc_reg <= 1'b0;
      pos_reg <= 1'b0;
    end else begin
      if (st_cnt_reg != 3'h7)
        st_cnt_reg <= st_cnt_reg + 3'h1;
      rxc_reg <= RXC;
      if (POWER_DOWN || RXC != rxc_reg)
        rxc_cnt_reg <= 5'h00;
      else if (rxc_cnt_reg != 5'h1f)
        rxc_cnt_reg <= rxc_cnt_reg + 5'h01;
      // Sign of the last nonzero line level.
      if (POWER_DOWN || TX_NEG)
        pos_reg <= 1'b0;
      else if (TX_POS)
        pos_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  a_strap_time: assert property (STRAP_DONE == (st_cnt_reg > 3'h3))
    else $error("strap capture cycle");
  a_strap_hold: assert property ($past(STRAP_DONE) |->
    $stable(CTRL_WORD) && $stable(ADV_WORD)) else $error("straps moved");
  a_iso_float: assert property (
    RXD_OE == (STRAP_DONE && !ISOLATE_MODE)) else $error("mii drive");
  a_pd_sync: assert property (STRAP_DONE |->
    POWER_DOWN != $past(POWER_DOWN_N, 3)) else $error("power down lag");
  a_txc_shape: assert property ($rose(TXC) |=>
    TXC [*3] ##1 !TXC [*4] ##1 TXC) else $error("tx clock shape");
  a_step_up: assert property ($rose(TX_POS) |->
    !pos_reg && !$past(TX_NEG)) else $error("plus step order");
  a_step_down: assert property ($rose(TX_NEG) |->
    pos_reg && !$past(TX_POS)) else $error("minus step order");
  a_rxd_edge: assert property (!POWER_DOWN && $changed(RXD_O) |->
    $past(RXC, 2) && !$past(RXC)) else $error("rx nibble off edge");
  a_rxc_runs: assert property (rxc_cnt_reg < 5'h10)
    else $error("rx clock stopped");
endmodule

/* File: tb/pst_line_model.sv */
// Line partner that sends nibbles as three-level steps.
`timescale 1ns/1ns
module pst_line_model (
  input wire link_clk, // Line nibble clock.
  input wire [3:0] nib, // Nibble, bit 0 first.
  output reg pos = 1'b0, // Line plus.
  output reg neg = 1'b0 // Line minus.
);
  reg nrzi_reg = 1'b0;
  reg [1:0] step_reg = 2'h0;
  reg [3:0] cur;
  integer i;
  // Four bits per nibble period; the line holds between frames.
  // The nibble is taken once per period so a change never splits one.
  always @(posedge link_clk) begin
    cur = nib;
    for (i = 0; i < 4; i = i + 1) begin
      nrzi_reg = nrzi_reg ^ cur[i];
      if (nrzi_reg)
        step_reg = step_reg + 2'h1;
      pos = step_reg == 2'h1;
      neg = step_reg == 2'h3;
      if (i < 3)
        #40;
    end
  end
endmodule

/* File: tb/pst_top_test.sv */
// Bench for strap capture and the fast nibble datapath.
`timescale 1ns/1ns
module pst_top_test;
  reg CORE_CLK = 1'b0;
  reg RSTN = 1'b0;
  reg POWER_DOWN_N = 1'b1;
  reg TX_EN = 1'b0;
  reg FIBER_MODE_ENABLE_I = 1'b0;
  reg link_clk = 1'b0;
  reg link_on = 1'b0;
  reg [3:0] TXD = 4'h0;
  reg [3:0] line_nib = 4'h0;
  reg [11:0] strap = 12'h087;
  integer miscompares = 0;
  integer n_compared = 0;
  integer cyc = 0;
  wire [3:0] RXD_I, RXD_O;
  wire [4:0] STRAP_MGMT_ADDRESS;
  wire [15:0] CTRL_WORD, ADV_WORD;
  wire INT_N_I, RX_DV_I, RX_ER_I, COL_I, CRS_I, LED_SPEED_I, LED_DUPLEX_I;
  wire LED_ACT_I, RXD_OE, INT_N_O, INT_N_OE, RX_DV_O, RX_DV_OE, RX_ER_O;
  wire RX_ER_OE, COL_O, COL_OE, CRS_O, CRS_OE, LED_SPEED_O, LED_SPEED_OE;
  wire LED_DUPLEX_O, LED_DUPLEX_OE, LED_ACT_O, LED_ACT_OE, TXC, RXC;
  wire TX_POS, TX_NEG, RX_POS, RX_NEG, STRAP_DONE, CODING_LAYER_LOOPBACK;
  wire ISOLATE_MODE, RMII_MODE, REDUCED_BACK_TO_BACK, FIBER_MODE_ENABLE;
  wire FAR_END_FAULT_DISABLE, POWER_DOWN;
  wire [11:0] pin_oe = {{4{RXD_OE}}, INT_N_OE, RX_DV_OE, RX_ER_OE, COL_OE,
    CRS_OE, LED_SPEED_OE, LED_DUPLEX_OE, LED_ACT_OE};
  wire [11:0] pin_o = {RXD_O, INT_N_O, RX_DV_O, RX_ER_O, COL_O, CRS_O,
    LED_SPEED_O, LED_DUPLEX_O, LED_ACT_O};
  wire [5:0] modes_seen = {CODING_LAYER_LOOPBACK, ISOLATE_MODE, RMII_MODE,
    REDUCED_BACK_TO_BACK, FIBER_MODE_ENABLE, FAR_END_FAULT_DISABLE};
  // A shared pin shows the device while it drives, else the strap.
  assign {RXD_I, INT_N_I, RX_DV_I, RX_ER_I, COL_I, CRS_I, LED_SPEED_I,
    LED_DUPLEX_I, LED_ACT_I} = (pin_oe & pin_o) | (~pin_oe & strap);

  pst_top pst_top_i (.CORE_CLK, .RSTN, .RXD_I, .RXD_O, .RXD_OE, .INT_N_I,
    .INT_N_O, .INT_N_OE, .RX_DV_I, .RX_DV_O, .RX_DV_OE, .RX_ER_I, .RX_ER_O,
    .RX_ER_OE, .COL_I, .COL_O, .COL_OE, .CRS_I, .CRS_O, .CRS_OE,
    .LED_SPEED_I, .LED_SPEED_O, .LED_SPEED_OE, .LED_DUPLEX_I, .LED_DUPLEX_O,
    .LED_DUPLEX_OE, .LED_ACT_I, .LED_ACT_O, .LED_ACT_OE,
    .FIBER_MODE_ENABLE_I, .POWER_DOWN_N, .TXC, .TXD, .TX_EN, .RXC, .TX_POS,
    .TX_NEG, .RX_POS, .RX_NEG, .STRAP_DONE, .STRAP_MGMT_ADDRESS,
    .CODING_LAYER_LOOPBACK, .ISOLATE_MODE, .RMII_MODE, .REDUCED_BACK_TO_BACK,
    .FIBER_MODE_ENABLE, .FAR_END_FAULT_DISABLE, .POWER_DOWN, .CTRL_WORD,
    .ADV_WORD);

  pst_line_model pst_line_model_i (.link_clk(link_clk), .nib(line_nib),
    .pos(RX_POS), .neg(RX_NEG));

  initial begin
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  // The line clock stands still outside frames.
  initial begin
    #7;
    forever begin
      if (link_on)
        link_clk = ~link_clk;
      #80;
    end
  end

  task check(input [95:0] what, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask

  task close_out;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Later pin activity must not disturb what reset captured.
  task strap_case(input [11:0] pins, input fib, input [4:0] addr,
    input [5:0] modes, input [15:0] ctrl, input [15:0] adv);
    begin
      @(posedge CORE_CLK);
      RSTN <= 1'b0;
      strap <= pins;
      FIBER_MODE_ENABLE_I <= fib;
      repeat (6) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      repeat (8) @(posedge CORE_CLK);
      strap <= ~pins;
      FIBER_MODE_ENABLE_I <= !fib;
      repeat (8) @(negedge CORE_CLK);
      check("address", STRAP_MGMT_ADDRESS, addr);
      check("modes", modes_seen, modes);
      check("control", CTRL_WORD, ctrl);
      check("advert", ADV_WORD, adv);
      check("mii drive", RXD_OE, !modes[4]);
      check("leds", {LED_SPEED_O, LED_DUPLEX_O, LED_ACT_O, INT_N_O, RX_ER_O},
        {~ctrl[13], ~ctrl[8], 3'h6});
    end
  endtask

  task tx_steps(input [3:0] nib, input pdn, input [15:0] exp);
    reg [1:0] last;
    reg [15:0] n;
    integer i;
    begin
      @(posedge TXC);
      @(posedge CORE_CLK);
      TXD <= nib;
      TX_EN <= 1'b1;
      POWER_DOWN_N <= pdn;
      repeat (40) @(negedge CORE_CLK);
      n = 16'h0000;
      last = {TX_POS, TX_NEG};
      for (i = 0; i < 64; i = i + 1) begin
        @(negedge CORE_CLK);
        if ({TX_POS, TX_NEG} !== last)
          n = n + 16'h0001;
        last = {TX_POS, TX_NEG};
      end
      check("line steps", n, exp);
      check("power down", POWER_DOWN, !pdn);
    end
  endtask

  task rx_case(input [3:0] nib, input act);
    begin
      @(posedge CORE_CLK);
      TX_EN <= 1'b0;
      POWER_DOWN_N <= 1'b1;
      line_nib <= nib;
      link_on <= 1'b1;
      repeat (80) @(negedge CORE_CLK);
      check("rx nibble", RXD_O, nib);
      check("rx active", {RX_DV_O, CRS_O}, {2{act}});
      link_on <= 1'b0;
    end
  endtask

  always @(posedge CORE_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end

  initial begin
    strap_case(12'ha78, 1'b1, 5'h14, 6'h3f, 16'h2000, 16'h0021);
    strap_case(12'h083, 1'b0, 5'h01, 6'h00, 16'h1100, 16'h0061);
    strap_case(12'h087, 1'b0, 5'h01, 6'h00, 16'h3100, 16'h01e1);
    tx_steps(4'hf, 1'b1, 16'h0010);
    tx_steps(4'hf, 1'b0, 16'h0000);
    rx_case(4'hf, 1'b1);
    rx_case(4'h0, 1'b0);
    close_out;
  end
endmodule

bind pst_top pst_top_assertions pst_top_assertions_i (.CORE_CLK, .RSTN,
  .TXC, .RXC, .RXD_O, .RXD_OE, .TX_POS, .TX_NEG, .POWER_DOWN_N, .POWER_DOWN,
  .STRAP_DONE, .ISOLATE_MODE, .CTRL_WORD, .ADV_WORD);
